/* design/ext_irq_mask_priority.sv */
// extended interrupt enable and priority registers with request logic
//
// Contract
// - timer-three mask gates both overflow flags; 0 blocks both
// - comparator-one mask gates rise and fall flags into a request
// - comparator-zero mask gates rise and fall flags into a request
// - counter-array mask passes or blocks all counter-array requests
// - conversion-done mask passes end-of-conversion flag only while 1
// - window-compare mask passes window flag only while 1
// - rtc mask gates alarm and oscillator-fail flags into one request
// - smbus mask passes or blocks all smbus port requests
// - timer-three level bit: 1 high priority, 0 low
// - comparator-one level bit: 1 high priority, 0 low
// - comparator-zero level bit: 1 high priority, 0 low
// - counter-array level bit: 1 high priority, 0 low
// - conversion-done level bit: 1 high priority, 0 low
// - window-compare level bit: 1 high priority, 0 low
// - smbus level bit: 1 high priority, 0 low
// - global enable 0 blocks every source; 1 follows each mask
`timescale 1ns/1ps
`default_nettype none

`include "ext_irq_consts.svh"

module ext_irq_mask_priority
  import ext_irq_pkg::*;
#(
  parameter int SOURCES = `EXT_IRQ_SOURCES
) (
  input wire logic CLK_SYS_I, // system clock, 200 MHz
  input wire logic RST_N_I, // synchronous reset, active low
  input wire logic [7:0] SFR_ADDR_I, // special register address
  input wire logic SFR_WR_I, // write strobe
  input wire logic SFR_RD_I, // read strobe
  input wire logic [7:0] SFR_WDATA_I, // write data
  output logic [7:0] SFR_RDATA_O, // read data, one cycle later
  input wire logic GLOBAL_IRQ_ENABLE_I, // global enable level
  input wire logic TIMER_THREE_LOW_OVERFLOW_I, // timer low byte flag
  input wire logic TIMER_THREE_HIGH_OVERFLOW_I, // timer high byte flag
  input wire logic COMPARATOR_ONE_RISE_FLAG_I, // comparator one rise
  input wire logic COMPARATOR_ONE_FALL_FLAG_I, // comparator one fall
  input wire logic COMPARATOR_ZERO_RISE_FLAG_I, // comparator zero rise
  input wire logic COMPARATOR_ZERO_FALL_FLAG_I, // comparator zero fall
  input wire logic COUNTER_ARRAY_REQ_I, // any counter array flag
  input wire logic CONVERSION_DONE_FLAG_I, // converter done flag
  input wire logic WINDOW_COMPARE_FLAG_I, // converter window flag
  input wire logic CLOCK_ALARM_FLAG_I, // rtc alarm flag
  input wire logic CLOCK_OSC_FAIL_FLAG_I, // rtc oscillator fail flag
  input wire logic SMBUS_PORT_REQ_I, // any smbus port flag
  input wire logic VECTOR_TAKEN_I, // core vectors to presented irq
  input wire logic SERVICE_RETURN_I, // core leaves a service routine
  output logic [7:0] REQ_HIGH_O, // enabled high-level requests
  output logic [7:0] REQ_LOW_O, // enabled low-level requests
  output logic IRQ_O, // request presented to the core
  output logic IRQ_HIGH_O, // presented request is high level
  output logic [3:0] VECTOR_INDEX_O, // vector number of presented irq
  output logic [1:0] SERVICE_LEVEL_O // service nesting state
);

  irq_state_s s;
  irq_state_s next_s;
  src_vec_t flag_a;
  src_vec_t flag_b;
  src_vec_t level_vec;
  src_vec_t gate_high;
  src_vec_t gate_low;
  logic any_high;
  logic any_low;
  logic [2:0] idx_high;
  logic [2:0] idx_low;
  logic wr_enable;
  logic wr_priority;
  logic rd_enable;
  logic rd_priority;
  logic allow_high;
  logic allow_low;

  // ************************************************************
  // source flag grouping
  // ************************************************************
  always_comb begin
    flag_a = '0;
    flag_b = '0;
    flag_a[`BIT_TIMER_THREE] = TIMER_THREE_LOW_OVERFLOW_I;
    flag_b[`BIT_TIMER_THREE] = TIMER_THREE_HIGH_OVERFLOW_I;
    flag_a[`BIT_COMPARATOR_ONE] = COMPARATOR_ONE_RISE_FLAG_I;
    flag_b[`BIT_COMPARATOR_ONE] = COMPARATOR_ONE_FALL_FLAG_I;
    flag_a[`BIT_COMPARATOR_ZERO] = COMPARATOR_ZERO_RISE_FLAG_I;
    flag_b[`BIT_COMPARATOR_ZERO] = COMPARATOR_ZERO_FALL_FLAG_I;
    flag_a[`BIT_COUNTER_ARRAY] = COUNTER_ARRAY_REQ_I;
    flag_a[`BIT_CONVERSION_DONE] = CONVERSION_DONE_FLAG_I;
    flag_a[`BIT_WINDOW_COMPARE] = WINDOW_COMPARE_FLAG_I;
    flag_a[`BIT_RTC] = CLOCK_ALARM_FLAG_I;
    flag_b[`BIT_RTC] = CLOCK_OSC_FAIL_FLAG_I;
    flag_a[`BIT_SMBUS_PORT] = SMBUS_PORT_REQ_I;
  end

  // every priority bit maps one to one onto its source level
  assign level_vec = s.ext_priority;

  // ************************************************************
  // masking and level split
  // ************************************************************
  ext_irq_source_gate #(
    .SOURCES(SOURCES)
  ) u_gate (
    .flag_a_i(flag_a),
    .flag_b_i(flag_b),
    .mask_i(s.ext_enable),
    .level_i(level_vec),
    .global_i(GLOBAL_IRQ_ENABLE_I),
    .high_o(gate_high),
    .low_o(gate_low)
  );

  ext_irq_pick #(
    .SOURCES(SOURCES),
    .IDX_W(3)
  ) u_pick_high (
    .req_i(gate_high),
    .any_o(any_high),
    .index_o(idx_high)
  );

  ext_irq_pick #(
    .SOURCES(SOURCES),
    .IDX_W(3)
  ) u_pick_low (
    .req_i(gate_low),
    .any_o(any_low),
    .index_o(idx_low)
  );

  // ************************************************************
  // register decode
  // ************************************************************
  assign wr_enable = SFR_WR_I && (SFR_ADDR_I == `EXT_IRQ_ENABLE_ONE_ADDR);
  assign wr_priority = SFR_WR_I &&
                       (SFR_ADDR_I == `EXT_IRQ_PRIORITY_ONE_ADDR);
  assign rd_enable = SFR_RD_I && (SFR_ADDR_I == `EXT_IRQ_ENABLE_ONE_ADDR);
  assign rd_priority = SFR_RD_I &&
                       (SFR_ADDR_I == `EXT_IRQ_PRIORITY_ONE_ADDR);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s = s;

    if (wr_enable) begin
      next_s.ext_enable = SFR_WDATA_I;
    end
    if (wr_priority) begin
      next_s.ext_priority = SFR_WDATA_I;
    end

    // reads return the value held before a same-cycle write
    if (rd_enable) begin
      next_s.rdata = s.ext_enable;
    end else if (rd_priority) begin
      next_s.rdata = s.ext_priority;
    end else begin
      next_s.rdata = `EXT_IRQ_UNMAPPED_READ;
    end

    next_s.req_high = gate_high;
    next_s.req_low = gate_low;

    // nesting: a taken request records the level it was presented at
    unique case (s.svc)
      SVC_IDLE: begin
        if (VECTOR_TAKEN_I && s.irq) begin
          next_s.svc = s.irq_high ? SVC_HIGH : SVC_LOW;
        end
      end
      SVC_LOW: begin
        if (VECTOR_TAKEN_I && s.irq && s.irq_high) begin
          next_s.svc = SVC_NESTED;
        end else if (SERVICE_RETURN_I) begin
          next_s.svc = SVC_IDLE;
        end
      end
      SVC_HIGH: begin
        if (SERVICE_RETURN_I) begin
          next_s.svc = SVC_IDLE;
        end
      end
      SVC_NESTED: begin
        if (SERVICE_RETURN_I) begin
          next_s.svc = SVC_LOW;
        end
      end
    endcase

    // high waits only for high service; low waits for any service
    allow_high = (next_s.svc == SVC_IDLE) || (next_s.svc == SVC_LOW);
    allow_low = (next_s.svc == SVC_IDLE);

    if (allow_high && any_high) begin
      next_s.irq = 1'b1;
      next_s.irq_high = 1'b1;
      next_s.vector = `EXT_IRQ_VECTOR_BASE + {1'b0, idx_high};
    end else if (allow_low && any_low) begin
      next_s.irq = 1'b1;
      next_s.irq_high = 1'b0;
      next_s.vector = `EXT_IRQ_VECTOR_BASE + {1'b0, idx_low};
    end else begin
      next_s.irq = 1'b0;
      next_s.irq_high = 1'b0;
      next_s.vector = `EXT_IRQ_NO_VECTOR;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      s.ext_enable <= `EXT_IRQ_ENABLE_ONE_RST;
      s.ext_priority <= `EXT_IRQ_PRIORITY_ONE_RST;
      s.rdata <= `EXT_IRQ_UNMAPPED_READ;
      s.req_high <= 8'h00;
      s.req_low <= 8'h00;
      s.irq <= 1'b0;
      s.irq_high <= 1'b0;
      s.vector <= `EXT_IRQ_NO_VECTOR;
      s.svc <= SVC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign SFR_RDATA_O = s.rdata;
  assign REQ_HIGH_O = s.req_high;
  assign REQ_LOW_O = s.req_low;
  assign IRQ_O = s.irq;
  assign IRQ_HIGH_O = s.irq_high;
  assign VECTOR_INDEX_O = s.vector;
  assign SERVICE_LEVEL_O = s.svc;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence low_service_s;
    s.svc == SVC_LOW;
  endsequence

  sequence high_taken_s;
    VECTOR_TAKEN_I && s.irq && s.irq_high;
  endsequence

  sequence nested_service_s;
    s.svc == SVC_NESTED;
  endsequence

  chk_timer_mask_off: assert property (
    GLOBAL_IRQ_ENABLE_I && !s.ext_enable[`BIT_TIMER_THREE] &&
    !wr_enable && TIMER_THREE_HIGH_OVERFLOW_I
    |=> !REQ_HIGH_O[`BIT_TIMER_THREE] && !REQ_LOW_O[`BIT_TIMER_THREE]
  ) else $error("timer three request passed while masked");

  chk_rtc_second_flag: assert property (
    GLOBAL_IRQ_ENABLE_I && s.ext_enable[`BIT_RTC] &&
    !s.ext_priority[`BIT_RTC] && CLOCK_OSC_FAIL_FLAG_I
    |=> REQ_LOW_O[`BIT_RTC]
  ) else $error("rtc oscillator fail flag did not request");

  chk_global_block: assert property (
    !GLOBAL_IRQ_ENABLE_I |=> (REQ_HIGH_O == 8'h00) && (REQ_LOW_O == 8'h00)
  ) else $error("request passed with global enable off");

  chk_done_high_level: assert property (
    GLOBAL_IRQ_ENABLE_I && CONVERSION_DONE_FLAG_I &&
    s.ext_enable[`BIT_CONVERSION_DONE] &&
    s.ext_priority[`BIT_CONVERSION_DONE]
    |=> REQ_HIGH_O[`BIT_CONVERSION_DONE] &&
        !REQ_LOW_O[`BIT_CONVERSION_DONE]
  ) else $error("conversion done not at high level");

  chk_smbus_low_level: assert property (
    GLOBAL_IRQ_ENABLE_I && SMBUS_PORT_REQ_I &&
    s.ext_enable[`BIT_SMBUS_PORT] && !s.ext_priority[`BIT_SMBUS_PORT]
    |=> REQ_LOW_O[`BIT_SMBUS_PORT] && !REQ_HIGH_O[`BIT_SMBUS_PORT]
  ) else $error("smbus request not at low level");

  chk_high_first: assert property (
    (|s.req_high) && (s.svc == SVC_IDLE || s.svc == SVC_LOW)
    |-> IRQ_O && IRQ_HIGH_O &&
        (VECTOR_INDEX_O >= `EXT_IRQ_VECTOR_BASE)
  ) else $error("high request not presented first");

  chk_preempt_low: assert property (
    low_service_s ##0 high_taken_s |=> s.svc == SVC_NESTED
  ) else $error("high request did not preempt low service");

  chk_enable_write: assert property (
    wr_enable |=> s.ext_enable == $past(SFR_WDATA_I)
  ) else $error("enable register write lost");

  chk_priority_read: assert property (
    rd_priority && !wr_priority |=> SFR_RDATA_O == s.ext_priority
  ) else $error("priority register read wrong");

  chk_low_waits: assert property (
    s.svc == SVC_HIGH |-> !IRQ_O
  ) else $error("request presented during high service");

  chk_comp_one_mask: assert property (
    GLOBAL_IRQ_ENABLE_I && !s.ext_enable[`BIT_COMPARATOR_ONE] &&
    COMPARATOR_ONE_FALL_FLAG_I
    |=> !REQ_HIGH_O[`BIT_COMPARATOR_ONE] && !REQ_LOW_O[`BIT_COMPARATOR_ONE]
  ) else $error("comparator one request passed while masked");

  chk_comp_zero_mask: assert property (
    GLOBAL_IRQ_ENABLE_I && !s.ext_enable[`BIT_COMPARATOR_ZERO] &&
    COMPARATOR_ZERO_RISE_FLAG_I
    |=> !REQ_HIGH_O[`BIT_COMPARATOR_ZERO] && !REQ_LOW_O[`BIT_COMPARATOR_ZERO]
  ) else $error("comparator zero request passed while masked");

  chk_array_request: assert property (
    GLOBAL_IRQ_ENABLE_I && COUNTER_ARRAY_REQ_I &&
    s.ext_enable[`BIT_COUNTER_ARRAY] && !s.ext_priority[`BIT_COUNTER_ARRAY]
    |=> REQ_LOW_O[`BIT_COUNTER_ARRAY]
  ) else $error("counter array request lost");

  chk_window_high: assert property (
    GLOBAL_IRQ_ENABLE_I && WINDOW_COMPARE_FLAG_I &&
    s.ext_enable[`BIT_WINDOW_COMPARE] && s.ext_priority[`BIT_WINDOW_COMPARE]
    |=> REQ_HIGH_O[`BIT_WINDOW_COMPARE] && !REQ_LOW_O[`BIT_WINDOW_COMPARE]
  ) else $error("window compare not at high level");

  chk_rtc_high_level: assert property (
    GLOBAL_IRQ_ENABLE_I && CLOCK_ALARM_FLAG_I &&
    s.ext_enable[`BIT_RTC] && s.ext_priority[`BIT_RTC]
    |=> REQ_HIGH_O[`BIT_RTC] && !REQ_LOW_O[`BIT_RTC]
  ) else $error("rtc request not at high level");

  chk_nested_return: assert property (
    nested_service_s ##0 SERVICE_RETURN_I |=> s.svc == SVC_LOW
  ) else $error("return from nested service did not drop to low");

endmodule

`default_nettype wire

/* inc/ext_irq_consts.svh */
// constants for the extended interrupt mask and priority block
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

// ************************************************************
// register offsets and reset values
// ************************************************************
`define EXT_IRQ_ENABLE_ONE_ADDR 8'hE6
`define EXT_IRQ_PRIORITY_ONE_ADDR 8'hF6
`define EXT_IRQ_ENABLE_ONE_RST 8'h00
`define EXT_IRQ_PRIORITY_ONE_RST 8'h00
`define EXT_IRQ_UNMAPPED_READ 8'h00

// ************************************************************
// bit positions, shared by the enable and priority registers
// ************************************************************
`define BIT_TIMER_THREE 7
`define BIT_COMPARATOR_ONE 6
`define BIT_COMPARATOR_ZERO 5
`define BIT_COUNTER_ARRAY 4
`define BIT_CONVERSION_DONE 3
`define BIT_WINDOW_COMPARE 2
`define BIT_RTC 1
`define BIT_SMBUS_PORT 0

// ************************************************************
// vectoring
// ************************************************************
`define EXT_IRQ_SOURCES 8
`define EXT_IRQ_VECTOR_BASE 4'h7
`define EXT_IRQ_NO_VECTOR 4'h0

`endif

/* inc/ext_irq_pkg.sv */
// types for the extended interrupt mask and priority block
`default_nettype none

package ext_irq_pkg;

  // ************************************************************
  // service tracking
  // ************************************************************
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW = 2'b01,
    SVC_HIGH = 2'b10,
    SVC_NESTED = 2'b11
  } svc_e;

  typedef logic [7:0] src_vec_t;

  // ************************************************************
  // whole state of the top module
  // ************************************************************
  typedef struct packed {
    src_vec_t ext_enable;
    src_vec_t ext_priority;
    logic [7:0] rdata;
    src_vec_t req_high;
    src_vec_t req_low;
    logic irq;
    logic irq_high;
    logic [3:0] vector;
    svc_e svc;
  } irq_state_s;

endpackage

`default_nettype wire

/* design/ext_irq_source_gate.sv */
// per-source flag merge, mask and level split
`timescale 1ns/1ps
`default_nettype none

module ext_irq_source_gate #(
  parameter int SOURCES = 8
) (
  input wire logic [SOURCES-1:0] flag_a_i, // first pending flag
  input wire logic [SOURCES-1:0] flag_b_i, // second flag, 0 if none
  input wire logic [SOURCES-1:0] mask_i, // per-source enable
  input wire logic [SOURCES-1:0] level_i, // 1 = high priority
  input wire logic global_i, // global enable
  output logic [SOURCES-1:0] high_o, // enabled high requests
  output logic [SOURCES-1:0] low_o // enabled low requests
);

  genvar g;

  // ************************************************************
  // gating
  // ************************************************************
  generate
    for (g = 0; g < SOURCES; g++) begin : gen_src
      logic pend;
      // either flag of a source raises the one shared request
      assign pend = (flag_a_i[g] | flag_b_i[g]) & mask_i[g] & global_i;
      assign high_o[g] = pend & level_i[g];
      assign low_o[g] = pend & ~level_i[g];
    end
  endgenerate

endmodule

`default_nettype wire

/* design/ext_irq_pick.sv */
// lowest-numbered pending source wins within a level
`timescale 1ns/1ps
`default_nettype none

module ext_irq_pick #(
  parameter int SOURCES = 8,
  parameter int IDX_W = 3
) (
  input wire logic [SOURCES-1:0] req_i, // pending requests
  output logic any_o, // at least one pending
  output logic [IDX_W-1:0] index_o // winning source
);

  // ************************************************************
  // priority encoder
  // ************************************************************
  always_comb begin
    index_o = '0;
    // walk downward so the lowest set bit is left standing
    for (int i = SOURCES - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        index_o = IDX_W'(i);
      end
    end
    any_o = |req_i;
  end

endmodule

`default_nettype wire

/* bench/core_model.sv */
// behavioural model of the core's interrupt vectoring side
`timescale 1ns/1ps
`default_nettype none

module core_model (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic irq_i, // presented request
  input wire logic take_en_i, // core may vector
  input wire logic [3:0] take_wait_i, // cycles of delay before vectoring
  input wire logic ret_req_i, // leave one service routine
  output logic taken_o, // vector taken pulse
  output logic ret_o // service return pulse
);
  logic [3:0] cnt;
  logic [1:0] guard;

  // guard skips the cycles in which irq still shows the request just taken,
  // otherwise one request would be vectored twice
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      taken_o <= 1'b0;
      ret_o <= 1'b0;
      cnt <= 4'h0;
      guard <= 2'h0;
    end else begin
      ret_o <= ret_req_i;
      if (taken_o) begin
        taken_o <= 1'b0;
        guard <= 2'h2;
      end else if (guard != 2'h0) begin
        guard <= guard - 2'h1;
      end else if (take_en_i && irq_i) begin
        if (cnt == take_wait_i) begin
          taken_o <= 1'b1;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the extended interrupt mask and priority block
`timescale 1ns/1ps
`default_nettype none

`include "ext_irq_consts.svh"

module testbench;
  localparam logic [7:0] EN_A = `EXT_IRQ_ENABLE_ONE_ADDR;
  localparam logic [7:0] PR_A = `EXT_IRQ_PRIORITY_ONE_ADDR;
  localparam logic [7:0] HAS_SECOND = 8'hE2;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic glb = 1'b0;
  logic [7:0] fa = 8'h00;
  logic [7:0] fb = 8'h00;
  logic take_en = 1'b0;
  logic [3:0] take_wait = 4'h0;
  logic ret_req = 1'b0;
  logic taken;
  logic ret;
  logic [7:0] SFR_RDATA_O, REQ_HIGH_O, REQ_LOW_O;
  logic IRQ_O, IRQ_HIGH_O;
  logic [3:0] VECTOR_INDEX_O;
  logic [1:0] SERVICE_LEVEL_O;
  int mismatches = 0;
  int n_checks = 0;

  always #2.5 clk_sys = ~clk_sys;

  ext_irq_mask_priority u_dut (
    .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
    .SFR_RDATA_O(SFR_RDATA_O), .GLOBAL_IRQ_ENABLE_I(glb),
    .TIMER_THREE_LOW_OVERFLOW_I(fa[7]), .TIMER_THREE_HIGH_OVERFLOW_I(fb[7]),
    .COMPARATOR_ONE_RISE_FLAG_I(fa[6]), .COMPARATOR_ONE_FALL_FLAG_I(fb[6]),
    .COMPARATOR_ZERO_RISE_FLAG_I(fa[5]), .COMPARATOR_ZERO_FALL_FLAG_I(fb[5]),
    .COUNTER_ARRAY_REQ_I(fa[4]), .CONVERSION_DONE_FLAG_I(fa[3]),
    .WINDOW_COMPARE_FLAG_I(fa[2]), .CLOCK_ALARM_FLAG_I(fa[1]),
    .CLOCK_OSC_FAIL_FLAG_I(fb[1]), .SMBUS_PORT_REQ_I(fa[0]),
    .VECTOR_TAKEN_I(taken), .SERVICE_RETURN_I(ret),
    .REQ_HIGH_O(REQ_HIGH_O), .REQ_LOW_O(REQ_LOW_O), .IRQ_O(IRQ_O),
    .IRQ_HIGH_O(IRQ_HIGH_O), .VECTOR_INDEX_O(VECTOR_INDEX_O),
    .SERVICE_LEVEL_O(SERVICE_LEVEL_O)
  );

  core_model u_core (
    .clk_i(clk_sys), .rst_n_i(rst_n), .irq_i(IRQ_O), .take_en_i(take_en),
    .take_wait_i(take_wait), .ret_req_i(ret_req), .taken_o(taken),
    .ret_o(ret)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check_sig(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t output 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t read 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = SFR_RDATA_O;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_level(input logic [1:0] exp);
    #1;
    for (int i = 0; i < 30 && SERVICE_LEVEL_O !== exp; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check_sig({6'h00, exp}, {6'h00, SERVICE_LEVEL_O});
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_registers;
    logic [7:0] d;
    sfr_read(EN_A, d);
    check_rd(`EXT_IRQ_ENABLE_ONE_RST, d);
    sfr_read(PR_A, d);
    check_rd(`EXT_IRQ_PRIORITY_ONE_RST, d);
    sfr_write(EN_A, 8'hA5);
    sfr_write(PR_A, 8'h5A);
    sfr_write(8'hE7, 8'hFF);
    sfr_read(EN_A, d);
    check_rd(8'hA5, d);
    sfr_read(PR_A, d);
    check_rd(8'h5A, d);
    sfr_read(8'hE7, d);
    check_rd(`EXT_IRQ_UNMAPPED_READ, d);
    $display("test registers done");
  endtask

  // one flag of one source through mask and level
  task automatic test_one(input int b, input int k);
    logic [7:0] m;
    m = 8'h01 << b;
    sfr_write(EN_A, m);
    sfr_write(PR_A, 8'h00);
    @(posedge clk_sys);
    if (k == 0) begin
      fa <= m;
    end else begin
      fb <= m;
    end
    settle;
    check_sig(m, REQ_LOW_O);
    check_sig(8'h00, {7'h00, IRQ_HIGH_O});
    sfr_write(PR_A, m);
    settle;
    check_sig(m, REQ_HIGH_O);
    check_sig(8'h01, {7'h00, IRQ_HIGH_O});
    sfr_write(EN_A, ~m);
    settle;
    check_sig(8'h00, REQ_HIGH_O | REQ_LOW_O);
    @(posedge clk_sys);
    fa <= 8'h00;
    fb <= 8'h00;
  endtask

  task automatic test_source_scan;
    for (int b = 0; b < 8; b++) begin
      test_one(b, 0);
      if (HAS_SECOND[b]) begin
        test_one(b, 1);
      end
    end
    $display("test source scan done");
  endtask

  task automatic test_priority_global;
    sfr_write(EN_A, 8'hFF);
    sfr_write(PR_A, 8'h00);
    @(posedge clk_sys);
    fa <= 8'hFF;
    fb <= HAS_SECOND;
    settle;
    check_sig(8'hFF, REQ_LOW_O);
    check_sig(8'(`EXT_IRQ_VECTOR_BASE), {4'h0, VECTOR_INDEX_O});
    sfr_write(PR_A, 8'h82);
    settle;
    check_sig(8'h82, REQ_HIGH_O);
    check_sig(8'(`EXT_IRQ_VECTOR_BASE + `BIT_RTC),
              {4'h0, VECTOR_INDEX_O});
    @(posedge clk_sys);
    glb <= 1'b0;
    settle;
    check_sig(8'h00, REQ_HIGH_O | REQ_LOW_O);
    check_sig(8'h00, {7'h00, IRQ_O});
    @(posedge clk_sys);
    glb <= 1'b1;
    fa <= 8'h00;
    fb <= 8'h00;
    $display("test priority and global done");
  endtask

  task automatic pulse_return;
    @(posedge clk_sys);
    ret_req <= 1'b1;
    @(posedge clk_sys);
    ret_req <= 1'b0;
  endtask

  // low service, then a high request pre-empts it; slow core vectoring
  task automatic test_nesting;
    sfr_write(EN_A, 8'h88);
    sfr_write(PR_A, 8'h80);
    @(posedge clk_sys);
    fa <= 8'h08;
    settle;
    check_sig(8'h01, {7'h00, IRQ_O});
    check_sig(8'(`EXT_IRQ_VECTOR_BASE + `BIT_CONVERSION_DONE),
              {4'h0, VECTOR_INDEX_O});
    @(posedge clk_sys);
    take_wait <= 4'h2;
    take_en <= 1'b1;
    wait_level(2'd1);
    settle;
    check_sig(8'h00, {7'h00, IRQ_O});
    @(posedge clk_sys);
    fb <= 8'h80;
    wait_level(2'd3);
    settle;
    check_sig(8'h00, {7'h00, IRQ_O});
    @(posedge clk_sys);
    take_en <= 1'b0;
    pulse_return;
    wait_level(2'd1);
    pulse_return;
    wait_level(2'd0);
    settle;
    check_sig(8'h01, {7'h00, IRQ_HIGH_O});
    check_sig(8'(`EXT_IRQ_VECTOR_BASE + `BIT_TIMER_THREE),
              {4'h0, VECTOR_INDEX_O});
    @(posedge clk_sys);
    fa <= 8'h00;
    fb <= 8'h00;
    $display("test nesting done");
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_registers;
    @(posedge clk_sys);
    glb <= 1'b1;
    test_source_scan;
    test_priority_global;
    test_nesting;
    report_and_stop;
  end

  // whole run needs well under 3000 cycles
  initial begin
    #100us;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
